// [verilog/dtr_pkg.sv]
// Shared selectors, field positions, reset values and timing for the sensor register block.
package dtr_pkg;

  // Register selectors carried in the command byte.
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
  localparam logic [7:0] CMD_HI_SEL [3] = '{8'h10, 8'h11, 8'h12};
  localparam logic [7:0] CMD_LO_SEL [3] = '{8'h20, 8'h21, 8'h22};
  localparam logic [7:0] CMD_MAKER = 8'hfe;
  localparam logic [7:0] CMD_REVISION = 8'hff;

  // Status and configuration field positions.
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_SECOND_MISSING_BIT = 1;
  localparam int STAT_FIRST_MISSING_BIT = 0;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_RATE_HI_BIT = 5;
  localparam int CFG_RATE_LO_BIT = 4;
  localparam int CFG_SECOND_FMT_BIT = 2;
  localparam int CFG_FIRST_FMT_BIT = 1;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h76;

  // Forced results for a missing remote diode.
  localparam logic [15:0] MISSING_UNSIGNED = 16'hffe0;
  localparam logic [15:0] MISSING_SIGNED = 16'h8000;

  // Conversion timing, in milliseconds and in cycles of the 50 MHz clock.
  localparam int CLK_KHZ = 50000;
  localparam int LOCAL_CONV_MS = 14;
  localparam int REMOTE_CONV_MS = 26;
  localparam int INTERVAL0_MS = 66;
  localparam int INTERVAL1_MS = 200;
  localparam int INTERVAL2_MS = 1000;
  localparam int INTERVAL3_MS = 3000;
  localparam int LOCAL_CONV_CYCLES = LOCAL_CONV_MS * CLK_KHZ;
  localparam int REMOTE_CONV_CYCLES = REMOTE_CONV_MS * CLK_KHZ;
  localparam int INTERVAL0_CYCLES = INTERVAL0_MS * CLK_KHZ;
  localparam int INTERVAL1_CYCLES = INTERVAL1_MS * CLK_KHZ;
  localparam int INTERVAL2_CYCLES = INTERVAL2_MS * CLK_KHZ;
  localparam int INTERVAL3_CYCLES = INTERVAL3_MS * CLK_KHZ;
  localparam int CNT_W = 28;

  // Kinds of byte transfer that the link hands to the register block.
  typedef enum logic [1:0] {REQ_COMMAND, REQ_WRITE, REQ_READ} dtr_req_kind_t;

endpackage : dtr_pkg

// [verilog/dtr_sync.sv]
// Two-flop synchroniser for a single level or toggle.
`timescale 1ns/10ps
module dtr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule : dtr_sync

// [verilog/dtr_sensor_regs.sv]
// Register set and conversion scheduler of a three-channel temperature sensor.
`timescale 1ns/10ps
module dtr_sensor_regs
  import dtr_pkg::*;
#(
  parameter int unsigned LOCAL_CYCLES = LOCAL_CONV_CYCLES,
  parameter int unsigned REMOTE_CYCLES = REMOTE_CONV_CYCLES,
  parameter int unsigned PERIOD0_CYCLES = INTERVAL0_CYCLES,
  parameter int unsigned PERIOD1_CYCLES = INTERVAL1_CYCLES,
  parameter int unsigned PERIOD2_CYCLES = INTERVAL2_CYCLES,
  parameter int unsigned PERIOD3_CYCLES = INTERVAL3_CYCLES,
  parameter logic [7:0] MAKER_ID = 8'h5a,    // Arbitrary value.
  parameter logic [7:0] DIE_REVISION = 8'h03  // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_req_valid,
  input wire dtr_req_kind_t link_req_kind,
  input wire logic [7:0] link_req_byte,
  output logic link_req_ready,
  output logic link_rd_valid,
  output logic [7:0] link_rd_data,
  input wire logic [9:0] local_raw,
  input wire logic [11:0] remote1_raw,
  input wire logic [11:0] remote2_raw,
  input wire logic remote1_fault,
  input wire logic remote2_fault,
  output logic [1:0] meas_channel,
  output logic conv_busy
);

  typedef enum logic [2:0] {ST_IDLE, ST_LOCAL, ST_REMOTE1, ST_REMOTE2, ST_WAIT} dtr_conv_state_t;

  // Refuse timing that the counters or the schedule cannot serve.
  if (LOCAL_CYCLES < 1 || REMOTE_CYCLES < 1 || PERIOD3_CYCLES >= (1 << CNT_W) ||
      PERIOD0_CYCLES < LOCAL_CYCLES + 2 * REMOTE_CYCLES || PERIOD1_CYCLES < PERIOD0_CYCLES ||
      PERIOD2_CYCLES < PERIOD1_CYCLES || PERIOD3_CYCLES < PERIOD2_CYCLES) begin : g_bad_timing
    $error("dtr_sensor_regs: conversion timing parameters out of range");
  end

  // Link side: request holding registers and handshake toggles.
  logic link_req_tgl_reg;
  dtr_req_kind_t link_kind_reg;
  logic [7:0] link_byte_reg;
  logic link_ack_sync;
  logic link_ack_seen_reg;
  logic link_ack_edge;
  // System side.
  logic req_sync;
  logic req_seen_reg;
  logic req_fire;
  logic ack_tgl_reg;
  logic [7:0] rd_word_reg;
  logic [7:0] pointer_reg;
  logic [7:0] config_reg;
  logic one_shot_pending_reg;
  logic first_missing_reg;
  logic second_missing_reg;
  logic [9:0] local_res_reg;
  logic [11:0] remote1_res_reg;
  logic [11:0] remote2_res_reg;
  dtr_conv_state_t state_reg;
  dtr_conv_state_t state_next;
  logic [CNT_W-1:0] phase_cnt_reg;
  logic [CNT_W-1:0] period_cnt_reg;
  logic [CNT_W-1:0] period_m1;
  logic phase_done;
  logic period_done;
  logic standby;
  logic start_ok;
  logic cycle_start;
  logic rd_fire;
  logic wr_fire;
  logic [15:0] chan_word [3];
  logic [7:0] lo_read [3];
  logic [7:0] read_mux;

  // Accept one request at a time and hand it over by a toggle.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_req_ready <= 1'b1;
      link_req_tgl_reg <= 1'b0;
      link_kind_reg <= REQ_READ;
      link_byte_reg <= 8'h00;
    end else if (link_req_valid && link_req_ready) begin
      link_req_ready <= 1'b0;
      link_req_tgl_reg <= ~link_req_tgl_reg;
      link_kind_reg <= link_req_kind;
      link_byte_reg <= link_req_byte;
    end else if (link_ack_edge) begin
      link_req_ready <= 1'b1;
    end
  end

  dtr_sync u_ack_sync (
    .clk(link_clk),
    .rst(rst),
    .async_in(ack_tgl_reg),
    .sync_out(link_ack_sync)
  );

  assign link_ack_edge = link_ack_sync ^ link_ack_seen_reg;

  // Return read data once the system side has answered; the word is stable by then.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_ack_seen_reg <= 1'b0;
      link_rd_valid <= 1'b0;
      link_rd_data <= 8'h00;
    end else begin
      link_ack_seen_reg <= link_ack_sync;
      link_rd_valid <= link_ack_edge && (link_kind_reg == REQ_READ);
      if (link_ack_edge && (link_kind_reg == REQ_READ)) begin
        link_rd_data <= rd_word_reg;
      end
    end
  end

  dtr_sync u_req_sync (
    .clk(clk),
    .rst(rst),
    .async_in(link_req_tgl_reg),
    .sync_out(req_sync)
  );

  assign req_fire = req_sync ^ req_seen_reg;
  assign rd_fire = req_fire && (link_kind_reg == REQ_READ);
  assign wr_fire = req_fire && (link_kind_reg == REQ_WRITE);
  assign standby = config_reg[CFG_STANDBY_BIT];

  // Answer each request once and flip the acknowledge toggle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rd_word_reg <= 8'h00;
    end else begin
      req_seen_reg <= req_sync;
      if (req_fire) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
      if (rd_fire) begin
        rd_word_reg <= read_mux;
      end
    end
  end

  // The pointer only moves on a command byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pointer_reg <= POINTER_RESET;
    end else if (req_fire && (link_kind_reg == REQ_COMMAND)) begin
      pointer_reg <= link_byte_reg;
    end
  end

  // Configuration writes keep reserved bits at zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_fire && (pointer_reg == CMD_CONFIG)) begin
      config_reg <= link_byte_reg & CONFIG_WRITE_MASK;
    end
  end

  // A one-shot request counts only in standby; a new request beats its consumption.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      one_shot_pending_reg <= 1'b0;
    end else if (wr_fire && (pointer_reg == CMD_ONE_SHOT) && standby) begin
      one_shot_pending_reg <= 1'b1;
    end else if (cycle_start && (state_reg == ST_IDLE)) begin
      one_shot_pending_reg <= 1'b0;
    end
  end

  // Interval chosen by the rate field.
  always_comb begin
    case (config_reg[CFG_RATE_HI_BIT:CFG_RATE_LO_BIT])
      2'b00: period_m1 = CNT_W'(PERIOD0_CYCLES - 1);
      2'b01: period_m1 = CNT_W'(PERIOD1_CYCLES - 1);
      2'b10: period_m1 = CNT_W'(PERIOD2_CYCLES - 1);
      default: period_m1 = CNT_W'(PERIOD3_CYCLES - 1);
    endcase
  end

  assign phase_done = (phase_cnt_reg == '0);
  assign period_done = (period_cnt_reg >= period_m1);
  assign start_ok = !standby || one_shot_pending_reg;
  assign cycle_start = (state_next == ST_LOCAL) && (state_reg != ST_LOCAL);

  // Conversion sequence: local, first remote, second remote, then wait out the interval.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          state_next = ST_LOCAL;
        end
      end
      ST_LOCAL: begin
        if (phase_done) begin
          state_next = ST_REMOTE1;
        end
      end
      ST_REMOTE1: begin
        if (phase_done) begin
          state_next = ST_REMOTE2;
        end
      end
      ST_REMOTE2: begin
        if (phase_done) begin
          if (standby) begin
            state_next = ST_IDLE;
          end else if (period_done) begin
            state_next = ST_LOCAL;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (standby) begin
          state_next = ST_IDLE;
        end else if (period_done) begin
          state_next = ST_LOCAL;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State and the outputs that follow it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      conv_busy <= 1'b0;
      meas_channel <= 2'b00;
    end else begin
      state_reg <= state_next;
      conv_busy <= (state_next == ST_LOCAL) || (state_next == ST_REMOTE1) ||
                   (state_next == ST_REMOTE2);
      case (state_next)
        ST_REMOTE1: meas_channel <= 2'b01;
        ST_REMOTE2: meas_channel <= 2'b10;
        default: meas_channel <= 2'b00;
      endcase
    end
  end

  // Phase length and position within the interval.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_cnt_reg <= '0;
      period_cnt_reg <= '0;
    end else begin
      if (state_next != state_reg || cycle_start) begin
        case (state_next)
          ST_LOCAL: phase_cnt_reg <= CNT_W'(LOCAL_CYCLES - 1);
          ST_REMOTE1, ST_REMOTE2: phase_cnt_reg <= CNT_W'(REMOTE_CYCLES - 1);
          default: phase_cnt_reg <= '0;
        endcase
      end else if (!phase_done) begin
        phase_cnt_reg <= phase_cnt_reg - 1'b1;
      end
      if (cycle_start) begin
        period_cnt_reg <= '0;
      end else if (state_reg != ST_IDLE) begin
        period_cnt_reg <= period_cnt_reg + 1'b1;
      end
    end
  end

  // Capture each channel's result, and each remote channel's fault state, at the end of its phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      local_res_reg <= '0;
      remote1_res_reg <= '0;
      remote2_res_reg <= '0;
      first_missing_reg <= 1'b0;
      second_missing_reg <= 1'b0;
    end else if (phase_done) begin
      if (state_reg == ST_LOCAL) begin
        local_res_reg <= local_raw;
      end
      if (state_reg == ST_REMOTE1) begin
        remote1_res_reg <= remote1_raw;
        first_missing_reg <= remote1_fault;
      end
      if (state_reg == ST_REMOTE2) begin
        remote2_res_reg <= remote2_raw;
        second_missing_reg <= remote2_fault;
      end
    end
  end

  // Format a remote result held in eighths of a degree, range -128 to 255.875.
  function automatic logic [15:0] fmt_remote(input logic [11:0] raw, input logic miss,
                                             input logic sgn);
    logic [10:0] val;
    val = raw[10:0];
    if (sgn && !raw[11] && raw[10]) begin
      val = 11'h3ff;
    end else if (!sgn && raw[11]) begin
      val = 11'h000;
    end
    if (miss) begin
      fmt_remote = sgn ? MISSING_SIGNED : MISSING_UNSIGNED;
    end else begin
      fmt_remote = {val, 5'h00};
    end
  endfunction : fmt_remote

  assign chan_word[0] = {local_res_reg, 6'h00};
  assign chan_word[1] = fmt_remote(remote1_res_reg, first_missing_reg,
                                   config_reg[CFG_FIRST_FMT_BIT]);
  assign chan_word[2] = fmt_remote(remote2_res_reg, second_missing_reg,
                                   config_reg[CFG_SECOND_FMT_BIT]);

  // Per channel low-byte freeze; the power-up selector counts as the local high byte.
  for (genvar ch = 0; ch < 3; ch++) begin : g_lock
    logic lock_reg;
    logic [7:0] hold_reg;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lock_reg <= 1'b0;
        hold_reg <= 8'h00;
      end else if (rd_fire && (pointer_reg == CMD_HI_SEL[ch] ||
                               (ch == 0 && pointer_reg == POINTER_RESET))) begin
        lock_reg <= 1'b1;
        hold_reg <= chan_word[ch][7:0];
      end else if (rd_fire && (pointer_reg == CMD_LO_SEL[ch])) begin
        lock_reg <= 1'b0;
      end
    end

    assign lo_read[ch] = lock_reg ? hold_reg : chan_word[ch][7:0];
  end

  // Read multiplexer.
  always_comb begin
    case (pointer_reg)
      CMD_STATUS: read_mux = {conv_busy, 5'b00000, second_missing_reg, first_missing_reg};
      CMD_CONFIG: read_mux = config_reg;
      CMD_HI_SEL[0], POINTER_RESET: read_mux = chan_word[0][15:8];
      CMD_HI_SEL[1]: read_mux = chan_word[1][15:8];
      CMD_HI_SEL[2]: read_mux = chan_word[2][15:8];
      CMD_LO_SEL[0]: read_mux = lo_read[0];
      CMD_LO_SEL[1]: read_mux = lo_read[1];
      CMD_LO_SEL[2]: read_mux = lo_read[2];
      CMD_MAKER: read_mux = MAKER_ID;
      CMD_REVISION: read_mux = DIE_REVISION;
      default: read_mux = 8'h00;
    endcase
  end

  // Checks on the register behaviour and the schedule.
  property p_cmd_latch;
    @(posedge clk) disable iff (rst)
    req_fire && (link_kind_reg == REQ_COMMAND) |=> pointer_reg == $past(link_byte_reg);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("pointer not loaded");

  property p_pointer_hold;
    @(posedge clk) disable iff (rst)
    !(req_fire && (link_kind_reg == REQ_COMMAND)) |=> $stable(pointer_reg);
  endproperty
  a_pointer_hold: assert property (p_pointer_hold) else $error("pointer moved");

  property p_status_read;
    @(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_STATUS) |=>
      rd_word_reg == {$past(conv_busy), 5'b00000, $past(second_missing_reg),
                      $past(first_missing_reg)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_config_reserved;
    @(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_CONFIG) |=> (rd_word_reg & 8'h89) == 8'h00;
  endproperty
  a_config_reserved: assert property (p_config_reserved) else $error("reserved set");

  property p_standby_idle;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE) && standby && !one_shot_pending_reg |=> state_reg == ST_IDLE;
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("standby left");

  property p_local_len;
    @(posedge clk) disable iff (rst)
    $rose(state_reg == ST_LOCAL) |-> phase_cnt_reg == CNT_W'(LOCAL_CYCLES - 1) && conv_busy;
  endproperty
  a_local_len: assert property (p_local_len) else $error("local phase length");

  property p_one_shot_start;
    @(posedge clk) disable iff (rst)
    wr_fire && (pointer_reg == CMD_ONE_SHOT) && standby && (state_reg == ST_IDLE)
      |-> ##[1:3] (state_reg == ST_LOCAL);
  endproperty
  a_one_shot_start: assert property (p_one_shot_start) else $error("one-shot lost");

  property p_one_shot_end;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_REMOTE2) && phase_done && standby |=> state_reg == ST_IDLE && !conv_busy;
  endproperty
  a_one_shot_end: assert property (p_one_shot_end) else $error("no standby return");

  property p_run_ignores_shot;
    @(posedge clk) disable iff (rst)
    wr_fire && (pointer_reg == CMD_ONE_SHOT) && !standby && !one_shot_pending_reg
      |=> !one_shot_pending_reg;
  endproperty
  a_run_ignores_shot: assert property (p_run_ignores_shot) else $error("shot taken");

  property p_missing_signed;
    @(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_HI_SEL[1]) && first_missing_reg &&
      config_reg[CFG_FIRST_FMT_BIT] |=> rd_word_reg == MISSING_SIGNED[15:8];
  endproperty
  a_missing_signed: assert property (p_missing_signed) else $error("missing value");

  property p_lo_freeze;
    @(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_HI_SEL[1]) |=>
      g_lock[1].lock_reg && g_lock[1].hold_reg == $past(chan_word[1][7:0]);
  endproperty
  a_lo_freeze: assert property (p_lo_freeze) else $error("low byte not frozen");

  property p_link_ready;
    @(posedge link_clk) disable iff (rst)
    link_req_valid && link_req_ready |=> !link_req_ready;
  endproperty
  a_link_ready: assert property (p_link_ready) else $error("ready not dropped");

  c_one_shot: cover property (@(posedge clk) disable iff (rst)
    (state_reg == ST_REMOTE2) && phase_done && standby);
  c_missing: cover property (@(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_HI_SEL[2]) && second_missing_reg);
  c_frozen_lo: cover property (@(posedge clk) disable iff (rst)
    rd_fire && (pointer_reg == CMD_LO_SEL[1]) && g_lock[1].lock_reg);
  c_link_read: cover property (@(posedge link_clk) disable iff (rst) link_rd_valid);

endmodule : dtr_sensor_regs

// [tb/dtr_host_model.sv]
// Link-side host model that issues command, write and read byte requests.
`timescale 1ns/10ps
module dtr_host_model
  import dtr_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_req_ready,
  input wire logic link_rd_valid,
  input wire logic [7:0] link_rd_data,
  output logic link_req_valid,
  output dtr_req_kind_t link_req_kind,
  output logic [7:0] link_req_byte
);
  // The request lines start idle.
  initial begin
    link_req_valid = 1'b0;
    link_req_kind = REQ_READ;
    link_req_byte = 8'h00;
  end

  // Holds a request until taken, then waits for the answer.
  task automatic xfer(input dtr_req_kind_t k, input logic [7:0] b, output logic [7:0] rd);
    int n;
    rd = 8'hxx;
    @(posedge link_clk);
    link_req_valid <= 1'b1;
    link_req_kind <= k;
    link_req_byte <= b;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_req_ready !== 1'b1 && n < 40);
    link_req_valid <= 1'b0;
    link_req_byte <= ~b; // A released byte line shows no stale value.
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_req_ready !== 1'b1 && n < 40);
    if (k == REQ_READ && link_rd_valid === 1'b1) begin
      rd = link_rd_data;
    end
  endtask : xfer
endmodule : dtr_host_model

// [tb/tb_top.sv]
// Self-checking bench for the sensor register block.
`timescale 1ns/10ps
module tb_top
  import dtr_pkg::*;
;
  localparam int LC = 20;
  localparam int RC = 30;
  localparam int PER [4] = '{100, 200, 400, 800};
  localparam logic [7:0] MID = 8'h3c; // Arbitrary value.
  localparam logic [7:0] RID = 8'h07; // Arbitrary value.
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic link_req_valid, link_req_ready, link_rd_valid, conv_busy;
  dtr_req_kind_t link_req_kind;
  logic [7:0] link_req_byte, link_rd_data, d;
  logic [9:0] local_raw = 10'h065;
  logic [11:0] remote1_raw = 12'h0c9;
  logic [11:0] remote2_raw = 12'hf38;
  logic remote1_fault = 1'b0;
  logic remote2_fault = 1'b0;
  logic busy_q = 1'b0;
  logic [1:0] meas_channel;
  logic [15:0] w;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int rise_t = 0;

  dtr_sensor_regs #(.LOCAL_CYCLES(LC), .REMOTE_CYCLES(RC), .PERIOD0_CYCLES(PER[0]),
    .PERIOD1_CYCLES(PER[1]), .PERIOD2_CYCLES(PER[2]), .PERIOD3_CYCLES(PER[3]),
    .MAKER_ID(MID), .DIE_REVISION(RID)) dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .link_req_valid(link_req_valid), .link_req_kind(link_req_kind),
    .link_req_byte(link_req_byte), .link_req_ready(link_req_ready),
    .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data), .local_raw(local_raw),
    .remote1_raw(remote1_raw), .remote2_raw(remote2_raw), .remote1_fault(remote1_fault),
    .remote2_fault(remote2_fault), .meas_channel(meas_channel), .conv_busy(conv_busy));

  dtr_host_model host (.link_clk(link_clk), .link_req_ready(link_req_ready),
    .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
    .link_req_valid(link_req_valid), .link_req_kind(link_req_kind),
    .link_req_byte(link_req_byte));

  // Two unrelated clocks.
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #3;
    forever #62.5 link_clk = ~link_clk;
  end

  // Cycle count, busy rise time and the hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    busy_q <= conv_busy;
    if (conv_busy === 1'b1 && busy_q !== 1'b1) rise_t <= cyc;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register access through the pointer.
  task automatic rd(input logic [7:0] sel, output logic [7:0] v);
    host.xfer(REQ_COMMAND, sel, v);
    host.xfer(REQ_READ, 8'h00, v);
  endtask : rd
  task automatic wr(input logic [7:0] sel, input logic [7:0] v);
    host.xfer(REQ_COMMAND, sel, d);
    host.xfer(REQ_WRITE, v, d);
  endtask : wr
  task automatic rd16(input int ch, output logic [15:0] v);
    rd(CMD_HI_SEL[ch], v[15:8]);
    rd(CMD_LO_SEL[ch], v[7:0]);
  endtask : rd16

  // Waits, bounded, until the channel or busy output shows a value.
  task automatic wait_for(input bit on_ch, input logic [1:0] v);
    int n;
    n = 0;
    while ((on_ch ? meas_channel : {1'b0, conv_busy}) !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    // A wait that runs out counts against the run.
    if (n >= 2000) begin
      mismatches++;
    end
  endtask : wait_for

  task automatic count_busy(output int n);
    n = 0;
    repeat (PER[3]) begin
      @(posedge clk);
      if (conv_busy !== 1'b0) n++;
    end
  endtask : count_busy

  // Power-up pointer, identity, reset value, reserved bits and empty selectors.
  task automatic t_regs;
    repeat (2 * PER[0]) @(posedge clk);
    host.xfer(REQ_READ, 8'h00, d);
    chk("power-up pointer", 16'h0019, {8'h00, d});
    rd(CMD_CONFIG, d);
    chk("config reset", 16'h0000, {8'h00, d});
    rd(CMD_MAKER, d);
    chk("maker id", {8'h00, MID}, {8'h00, d});
    rd(CMD_REVISION, d);
    chk("die_revision", {8'h00, RID}, {8'h00, d});
    rd(CMD_STATUS, d);
    chk("status reserved", 16'h0000, {8'h00, d & 8'h7c});
    wr(8'h05, 8'hff);
    rd(8'h05, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    rd(CMD_CONFIG, d);
    chk("config after stray write", 16'h0000, {8'h00, d});
    rd(CMD_ONE_SHOT, d);
    chk("one-shot read", 16'h0000, {8'h00, d});
    wr(CMD_CONFIG, 8'hff);
    rd(CMD_CONFIG, d);
    chk("config mask", 16'h0076, {8'h00, d});
  endtask : t_regs

  // Formats differ between the two remote channels in every pass and faults in two of the four, so swapped fields show.
  task automatic t_format;
    logic [15:0] r1, r2;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      remote1_fault <= i[1];
      remote2_fault <= i[1] ^ i[0];
      wr(CMD_CONFIG, i[0] ? 8'h02 : 8'h04);
      repeat (2 * PER[0]) @(posedge clk);
      r1 = i[1] ? (i[0] ? 16'h8000 : 16'hffe0) : 16'h1920;
      r2 = (i[1] ^ i[0]) ? (i[0] ? 16'hffe0 : 16'h8000) : (i[0] ? 16'h0000 : 16'he700);
      rd16(0, w);
      chk("local word", 16'h1940, w);
      rd16(1, w);
      chk("remote1 word", r1, w);
      rd16(2, w);
      chk("remote2 word", r2, w);
      rd(CMD_STATUS, d);
      chk("status flags", {14'h0, i[1] ^ i[0], i[1]}, {8'h00, d & 8'h7f});
    end
    @(posedge clk);
    remote1_fault <= 1'b0;
    remote2_fault <= 1'b0;
  endtask : t_format

  // A high read holds its low byte until that is read.
  task automatic t_freeze;
    rd(CMD_HI_SEL[0], d);
    @(posedge clk);
    local_raw <= 10'h0a7;
    repeat (2 * PER[0]) @(posedge clk);
    rd(CMD_LO_SEL[0], d);
    chk("frozen low", 16'h0040, {8'h00, d});
    host.xfer(REQ_READ, 8'h00, d);
    chk("live low", 16'h00c0, {8'h00, d});
    rd(CMD_HI_SEL[0], d);
    chk("new high", 16'h0029, {8'h00, d});
  endtask : t_freeze

  // Phase lengths and interval of every rate code.
  task automatic t_rate;
    int t0;
    for (int r = 0; r < 4; r++) begin
      wr(CMD_CONFIG, 8'(r << 4));
      wr(CMD_ONE_SHOT, 8'h00);
      wait_for(0, 2'd0);
      wait_for(0, 2'd1);
      t0 = cyc;
      wait_for(1, 2'd1);
      chk("local phase", 16'(LC), 16'(cyc - t0));
      wait_for(1, 2'd2);
      chk("remote1 phase", 16'(LC + RC), 16'(cyc - t0));
      wait_for(0, 2'd0);
      chk("cycle length", 16'(LC + 2 * RC), 16'(cyc - t0));
      wait_for(0, 2'd1);
      chk("interval", 16'(PER[r]), 16'(cyc - t0));
    end
    // A slow-rate cycle has just begun, so the busy bit must read one.
    rd(CMD_STATUS, d);
    chk("status busy", 16'h0080, {8'h00, d});
  endtask : t_rate

  // Standby stays idle; a one-shot runs one full cycle.
  task automatic t_standby;
    int n;
    wr(CMD_CONFIG, 8'h40);
    wait_for(0, 2'd0);
    count_busy(n);
    chk("standby idle", 16'h0000, 16'(n));
    rd(CMD_STATUS, d);
    chk("status idle", 16'h0000, {8'h00, d});
    wr(CMD_ONE_SHOT, 8'h5a);
    wait_for(0, 2'd1);
    wait_for(0, 2'd0);
    chk("one-shot length", 16'(LC + 2 * RC), 16'(cyc - rise_t));
    count_busy(n);
    chk("after one-shot", 16'h0000, 16'(n));
  endtask : t_standby

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_format();
    t_freeze();
    t_rate();
    t_standby();
    end_of_test();
  end
endmodule : tb_top
